// [include/bdfs_pkg.sv]
/*
 * bdfs_pkg: constants shared by the bridge driver fault supervisor.
 * Assumes a single 10 MHz core clock; every time is converted to cycles here.
 */
`default_nettype none
package bdfs_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PHASES = 3;
	localparam int PUMPS = 2;

	// minimum dead time, a least time: round up
	localparam int DEAD_MIN_NS = 50;
	localparam int DEAD_CYCLES = (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// short-detect integration delay; integrator decays at 1/SC_DECAY_DIV of the rise rate
	localparam int SC_DELAY_NS = 12000;
	localparam int SC_CYCLES = SC_DELAY_NS / CLK_PERIOD_NS;
	localparam int SC_DECAY_DIV = 4;

	localparam int OC_BLANK_NS = 1500;
	localparam int OC_BLANK_CYCLES = OC_BLANK_NS / CLK_PERIOD_NS;

	localparam int UV_FILTER_NS = 1000;
	localparam int UV_FILTER_CYCLES = UV_FILTER_NS / CLK_PERIOD_NS;

	// overvoltage must persist at least this long: round up
	localparam int OV_FILTER_NS = 30000;
	localparam int OV_FILTER_CYCLES = (OV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// enable-low reset: clears at 2.0 us, never at or below 0.5 us
	localparam int ENABLE_RESET_NS = 2000;
	localparam int ENABLE_RESET_CYCLES = (ENABLE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENABLE_NORESET_NS = 500;
	localparam int ENABLE_NORESET_CYCLES = ENABLE_NORESET_NS / CLK_PERIOD_NS;

	// logic wake-up after sleep inhibit rises, longest time: round down
	localparam int WAKE_NS = 5000000;
	localparam int WAKE_CYCLES_DEF = WAKE_NS / CLK_PERIOD_NS;

	localparam logic [1:0] FC_UV = 2'h0;
	localparam logic [1:0] FC_OT_OV = 2'h1;
	localparam logic [1:0] FC_SC_OC = 2'h2;
	localparam logic [1:0] FC_OK = 2'h3;
endpackage
`default_nettype wire

// [include/bdfs_phase_if.sv]
/*
 * bdfs_phase_if: signals between the supervisor and one half-bridge channel.
 * Assumes both ends share the core clock; no timing is carried here.
 */
`timescale 1ns/1ps
`default_nettype none
interface bdfs_phase_if;
	logic hs_cmd;
	logic ls_cmd;
	logic vds_hs_over;
	logic vds_ls_over;
	logic allow;
	logic sc_enable;
	logic hs_gate;
	logic ls_gate;
	logic short_trip;
	modport ctl(output hs_cmd, output ls_cmd, output vds_hs_over, output vds_ls_over, output allow,
		output sc_enable, input hs_gate, input ls_gate, input short_trip);
	modport bridge(input hs_cmd, input ls_cmd, input vds_hs_over, input vds_ls_over, input allow,
		input sc_enable, output hs_gate, output ls_gate, output short_trip);
endinterface
`default_nettype wire

// [hw/bdfs_filter.sv]
/*
 * bdfs_filter: persistence filter; output rises once the input has been high
 * for CYCLES consecutive clocks and falls on the first low input.
 * Assumes a synchronous input and the released internal reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bdfs_filter #(
	parameter int CYCLES = 10
) (
	input wire logic clk_in, // core clock
	input wire logic rst_n_in, // released reset
	input wire logic level_in, // raw condition
	output logic hit_out // filtered condition
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
		end else if (!level_in) begin
			cnt <= '0;
		end else if (cnt != CW'(CYCLES)) begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hit_out <= 1'b0;
		end else begin
			hit_out <= level_in & (hit_out | (cnt >= CW'(CYCLES - 1)));
		end
	end
endmodule
`default_nettype wire

// [hw/bdfs_half_bridge.sv]
/*
 * bdfs_half_bridge: one half bridge: shoot-through lockout, dead time and the
 * shared short-detect integrator of its two switches.
 * Assumes allow/sc_enable from the supervisor and a one-cycle decay tick.
 */
`timescale 1ns/1ps
`default_nettype none
module bdfs_half_bridge import bdfs_pkg::*; #(
	parameter int DEAD = DEAD_CYCLES,
	parameter int TRIP = SC_CYCLES
) (
	input wire logic clk_in, // core clock
	input wire logic rst_n_in, // released reset
	input wire logic clear_in, // enable-pin reset of the integrator
	input wire logic decay_tick_in, // slow decay enable pulse
	bdfs_phase_if.bridge ph // channel signals
);
	localparam int DW = $clog2(DEAD + 1);
	localparam int IW = $clog2(TRIP + 1);
	logic [DW-1:0] off_cnt;
	logic [IW-1:0] integ;
	logic want_hs;
	logic want_ls;
	logic dead_done;
	logic short_seen;

	assign want_hs = ph.allow & ph.hs_cmd & ~ph.ls_cmd;
	assign want_ls = ph.allow & ph.ls_cmd & ~ph.hs_cmd;
	assign dead_done = (off_cnt == DW'(DEAD));

	// cycles since either gate was last seen on
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			off_cnt <= '0;
		end else if (ph.hs_gate | ph.ls_gate) begin
			off_cnt <= '0;
		end else if (!dead_done) begin
			off_cnt <= off_cnt + 1'b1;
		end
	end

	// a gate turns on only after the opposite one has been off for the dead time
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph.hs_gate <= 1'b0;
			ph.ls_gate <= 1'b0;
		end else begin
			ph.hs_gate <= want_hs & (ph.hs_gate | (~ph.ls_gate & dead_done));
			ph.ls_gate <= want_ls & (ph.ls_gate | (~ph.hs_gate & dead_done));
		end
	end

	// a gate is only on after its dead time, so gating by it delays monitoring
	assign short_seen = ph.sc_enable & ((ph.hs_gate & ph.vds_hs_over) | (ph.ls_gate & ph.vds_ls_over));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			integ <= '0;
		end else if (clear_in) begin
			integ <= '0;
		end else if (short_seen) begin
			if (integ != IW'(TRIP)) begin
				integ <= integ + 1'b1;
			end
		end else if (decay_tick_in && integ != '0) begin
			integ <= integ - 1'b1;
		end
	end

	assign ph.short_trip = (integ == IW'(TRIP));
endmodule
`default_nettype wire

// [hw/bdfs_top.sv]
/*
 * bdfs_top: protection and diagnostic supervisor of a three-phase bridge
 * gate driver: gate command gating, latched and self-clearing faults, the
 * enable-pin reset, the host supply check, sleep/wake and the fault code.
 * Assumes all inputs are digital comparator results synchronous to MCLK_IN.
 */
// Functional notes
// - at least 50 ns, at most 200 ns dead time between half-bridge switches.
// - both commands on in one half bridge is ignored; never both gates on.
// - one shared short integrator per half bridge; rises on short, slowly decays.
// - short monitoring of a switch starts after its command and dead time.
// - short lasting about 12 us turns all switches off and latches the fault.
// - short-limit input at 5 V disables short protection, overcurrent warning unaffected.
// - overcurrent comparator passes 1.5 us blanking before raising its fault.
// - overcurrent only flags; clears when current drops or commutates to high side.
// - filtered pump undervoltage forces gates low and suspends short detection.
// - after undervoltage recovers, gates follow the commands again without reset.
// - filtered overvoltage turns off switches and pumps until enable-pin reset.
// - pump undervoltage caused by overvoltage is also shown on fault pins.
// - over-temperature raises a self-clearing warning; operation is unchanged.
// - host supply check armed by enable rising, active only while enable high.
// - supply check error disables outputs and latches until enable-pin reset.
// - fault pins: 00 UV/supply, 01 OT/OV, 10 short/OC, 11 no error.
// - both fault pins are always actively driven high or low.
// - faults never cause sleep; only sleep inhibit low does.
// - logic operational within 5 ms of sleep inhibit rising.
// - output stages disabled within 8 us of sleep inhibit falling.
// - enable low for 2.0 us clears latched faults and turns switches off.
// - enable low pulse up to 0.5 us does not clear latched faults.
// - while enable is low only undervoltage and over-temperature are shown.
// - fault priority: supply check, short, UV, OV, then OT and OC.
`timescale 1ns/1ps
`default_nettype none
module bdfs_top import bdfs_pkg::*; #(
	parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
	input wire logic MCLK_IN, // 10 MHz core clock
	input wire logic RST_N_IN, // power-on reset, active low
	input wire logic DRIVER_ENABLE_IN, // enable pin, high enables
	input wire logic SLEEP_INHIBIT_N_IN, // low puts the device to sleep
	input wire logic [PHASES-1:0] HIGH_SIDE_CMD_IN, // high-side gate commands
	input wire logic [PHASES-1:0] LOW_SIDE_CMD_IN, // low-side gate commands
	input wire logic [PHASES-1:0] HS_SHORT_DETECT_IN, // high-side drain-source above limit
	input wire logic [PHASES-1:0] LS_SHORT_DETECT_IN, // low-side drain-source above limit
	input wire logic SHORT_LIMIT_LEVEL_OFF_IN, // short limit level at 5 V
	input wire logic OVERCURRENT_CMP_IN, // shunt signal above threshold
	input wire logic OVERCURRENT_THRESHOLD_IN_GND_IN, // threshold tied to ground
	input wire logic [PUMPS-1:0] PUMP_BUFFER_CAP_UV_IN, // pump buffer below UV level
	input wire logic [1:0] SUPPLY_OV_IN, // supply / bridge drain sense overvoltage
	input wire logic OVERTEMP_IN, // junction above warning level
	input wire logic HOST_IO_SUPPLY_UV_IN, // host I/O supply too low
	input wire logic HOST_IO_SUPPLY_OV_IN, // host I/O supply too high
	output logic [PHASES-1:0] HIGH_SIDE_GATE_OUT, // high-side gate drive
	output logic [PHASES-1:0] LOW_SIDE_GATE_OUT, // low-side gate drive
	output logic [PUMPS-1:0] PUMP_ENABLE_OUT, // charge pump enables
	output logic LOGIC_READY_OUT, // awake and operational
	output logic FAULT_CODE_HI_OUT, // first fault code pin
	output logic FAULT_CODE_LO_OUT // second fault code pin
);
	localparam int WW = $clog2(WAKE_CYCLES + 1);
	localparam int EW = $clog2(ENABLE_RESET_CYCLES + 1);
	localparam int KW = $clog2(SC_DECAY_DIV);

	logic rst_meta;
	logic rst_n;
	logic [WW-1:0] wake_cnt;
	logic awake;
	logic enable_q;
	logic enable_rise;
	logic [EW-1:0] enable_low_cnt;
	logic latch_clear;
	logic vcc_armed;
	logic vcc_err;
	logic sc_lat;
	logic ov_lat;
	logic ov_f;
	logic [PUMPS-1:0] uv_f;
	logic uv_any;
	logic oc_f;
	logic oc_comm;
	logic oc_warn;
	logic gate_allow;
	logic [KW-1:0] decay_div;
	logic decay_tick;
	logic [PHASES-1:0] trip;
	logic [PHASES-1:0] hs_gate_q;
	logic [1:0] next_code;
	logic [1:0] code;

	// reset release through two flops
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// wake-up counter; sleep only comes from the inhibit pin, never from a fault
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt <= '0;
		end else if (!SLEEP_INHIBIT_N_IN) begin
			wake_cnt <= '0;
		end else if (wake_cnt != WW'(WAKE_CYCLES)) begin
			wake_cnt <= wake_cnt + 1'b1;
		end
	end
	// inhibit low drops awake at once, well inside the disable time
	assign awake = SLEEP_INHIBIT_N_IN & (wake_cnt == WW'(WAKE_CYCLES));
	assign LOGIC_READY_OUT = awake;

	// enable-low timer: only a low of the full reset time clears latches
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
			enable_low_cnt <= '0;
		end else begin
			enable_q <= DRIVER_ENABLE_IN;
			if (DRIVER_ENABLE_IN) begin
				enable_low_cnt <= '0;
			end else if (enable_low_cnt != EW'(ENABLE_RESET_CYCLES)) begin
				enable_low_cnt <= enable_low_cnt + 1'b1;
			end
		end
	end
	assign enable_rise = DRIVER_ENABLE_IN & ~enable_q;
	// clears on the last low sample of a full reset time; short pulses never get that far
	assign latch_clear = ~awake | (~DRIVER_ENABLE_IN & (enable_low_cnt >= EW'(ENABLE_RESET_CYCLES - 1))
		& (ENABLE_RESET_CYCLES > ENABLE_NORESET_CYCLES));

	// host supply check
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			vcc_armed <= 1'b0;
		end else begin
			vcc_armed <= awake & DRIVER_ENABLE_IN & (vcc_armed | enable_rise);
		end
	end
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			vcc_err <= 1'b0;
		end else begin
			// set wins over the enable-pin clear
			vcc_err <= (vcc_armed & DRIVER_ENABLE_IN & (HOST_IO_SUPPLY_UV_IN | HOST_IO_SUPPLY_OV_IN))
				| (vcc_err & ~latch_clear);
		end
	end

	// supply filters
	generate
		for (genvar p = 0; p < PUMPS; p++) begin : g_uv
			bdfs_filter #(.CYCLES(UV_FILTER_CYCLES)) u_uv (
				.clk_in(MCLK_IN),
				.rst_n_in(rst_n),
				.level_in(PUMP_BUFFER_CAP_UV_IN[p]),
				.hit_out(uv_f[p])
			);
		end
	endgenerate
	assign uv_any = |uv_f;

	bdfs_filter #(.CYCLES(OV_FILTER_CYCLES)) u_ov (
		.clk_in(MCLK_IN),
		.rst_n_in(rst_n),
		.level_in(|SUPPLY_OV_IN),
		.hit_out(ov_f)
	);

	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ov_lat <= 1'b0;
		end else begin
			ov_lat <= (awake & ov_f) | (ov_lat & ~latch_clear);
		end
	end

	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			PUMP_ENABLE_OUT <= '0;
		end else begin
			PUMP_ENABLE_OUT <= {PUMPS{awake & ~ov_lat}};
		end
	end

	// gates follow commands while awake and enabled with no blocking fault present; UV is not latched
	assign gate_allow = awake & DRIVER_ENABLE_IN & ~sc_lat & ~ov_lat & ~vcc_err & ~uv_any;

	// slow decay rate for the short integrators
	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			decay_div <= '0;
		end else begin
			decay_div <= decay_div + 1'b1;
		end
	end
	assign decay_tick = (decay_div == '0);

	generate
		for (genvar h = 0; h < PHASES; h++) begin : g_hb
			bdfs_phase_if ph ();
			assign ph.hs_cmd = HIGH_SIDE_CMD_IN[h];
			assign ph.ls_cmd = LOW_SIDE_CMD_IN[h];
			assign ph.vds_hs_over = HS_SHORT_DETECT_IN[h];
			assign ph.vds_ls_over = LS_SHORT_DETECT_IN[h];
			assign ph.allow = gate_allow;
			// UV suspends detection so a brown-out cannot latch a shutdown
			assign ph.sc_enable = ~SHORT_LIMIT_LEVEL_OFF_IN & ~uv_any;
			assign HIGH_SIDE_GATE_OUT[h] = ph.hs_gate;
			assign LOW_SIDE_GATE_OUT[h] = ph.ls_gate;
			assign trip[h] = ph.short_trip;
			bdfs_half_bridge u_hb (
				.clk_in(MCLK_IN),
				.rst_n_in(rst_n),
				.clear_in(latch_clear),
				.decay_tick_in(decay_tick),
				.ph(ph.bridge)
			);
		end
	endgenerate

	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sc_lat <= 1'b0;
		end else begin
			sc_lat <= (|trip) | (sc_lat & ~latch_clear);
		end
	end

	// overcurrent warning: blanking filter, then self-clearing flag
	bdfs_filter #(.CYCLES(OC_BLANK_CYCLES)) u_oc (
		.clk_in(MCLK_IN),
		.rst_n_in(rst_n),
		.level_in(OVERCURRENT_CMP_IN & ~OVERCURRENT_THRESHOLD_IN_GND_IN),
		.hit_out(oc_f)
	);

	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			hs_gate_q <= '0;
			oc_comm <= 1'b0;
		end else begin
			hs_gate_q <= HIGH_SIDE_GATE_OUT;
			// commutation to a high side hides the warning until the comparator drops
			oc_comm <= oc_f & (oc_comm | (|(HIGH_SIDE_GATE_OUT & ~hs_gate_q)));
		end
	end
	assign oc_warn = oc_f & ~oc_comm;

	// fault code by priority; only UV and OT show while disabled
	always_comb begin
		next_code = FC_OK;
		if (!awake) begin
			next_code = FC_OK;
		end else if (DRIVER_ENABLE_IN && vcc_err) begin
			next_code = FC_UV;
		end else if (DRIVER_ENABLE_IN && sc_lat) begin
			next_code = FC_SC_OC;
		end else if (uv_any) begin
			// OV discharges the pumps, so its UV shows here too
			next_code = FC_UV;
		end else if (DRIVER_ENABLE_IN && ov_lat) begin
			next_code = FC_OT_OV;
		end else if (OVERTEMP_IN) begin
			next_code = FC_OT_OV;
		end else if (DRIVER_ENABLE_IN && oc_warn) begin
			next_code = FC_SC_OC;
		end
	end

	always_ff @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			code <= FC_OK;
		end else begin
			code <= next_code;
		end
	end
	// push-pull pins, always a definite level
	assign FAULT_CODE_HI_OUT = code[1];
	assign FAULT_CODE_LO_OUT = code[0];
endmodule
`default_nettype wire

// [sim/bdfs_chk.sv]
/*
 * bdfs_chk: port-level assertions for the bridge driver fault supervisor.
 * Assumes it is bound to bdfs_top and runs on its single core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bdfs_chk import bdfs_pkg::*; (
	input wire logic MCLK_IN, // core clock
	input wire logic RST_N_IN, // reset, active low
	input wire logic DRIVER_ENABLE_IN, // enable pin
	input wire logic SLEEP_INHIBIT_N_IN, // low = sleep
	input wire logic [PHASES-1:0] HIGH_SIDE_CMD_IN, // high-side commands
	input wire logic [PHASES-1:0] LOW_SIDE_CMD_IN, // low-side commands
	input wire logic [PUMPS-1:0] PUMP_BUFFER_CAP_UV_IN, // pump undervoltage
	input wire logic [PHASES-1:0] HIGH_SIDE_GATE_OUT, // high-side gates
	input wire logic [PHASES-1:0] LOW_SIDE_GATE_OUT, // low-side gates
	input wire logic LOGIC_READY_OUT, // awake
	input wire logic FAULT_CODE_HI_OUT, // first code pin
	input wire logic FAULT_CODE_LO_OUT // second code pin
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire [PHASES-1:0] on = HIGH_SIDE_GATE_OUT | LOW_SIDE_GATE_OUT;
	wire [1:0] code = {FAULT_CODE_HI_OUT, FAULT_CODE_LO_OUT};

	AST_NO_SHOOT: assert property ((HIGH_SIDE_GATE_OUT & LOW_SIDE_GATE_OUT) == '0)
		else $error("both gates of a half bridge on");
	AST_DEAD_HS: assert property ((HIGH_SIDE_GATE_OUT & ~$past(HIGH_SIDE_GATE_OUT) & $past(LOW_SIDE_GATE_OUT)) == '0)
		else $error("high gate rose without dead time");
	AST_DEAD_LS: assert property ((LOW_SIDE_GATE_OUT & ~$past(LOW_SIDE_GATE_OUT) & $past(HIGH_SIDE_GATE_OUT)) == '0)
		else $error("low gate rose without dead time");
	AST_BOTH_CMD: assert property ((on & $past(HIGH_SIDE_CMD_IN & LOW_SIDE_CMD_IN)) == '0)
		else $error("conflicting commands not ignored");
	AST_SLEEP_OFF: assert property ($fell(SLEEP_INHIBIT_N_IN) |-> ##[1:80] on == '0)
		else $error("gates not off after sleep request");
	AST_ASLEEP_CODE: assert property (!LOGIC_READY_OUT |=> code == 2'b11)
		else $error("fault code shown while not awake");
	AST_UV_OFF: assert property (PUMP_BUFFER_CAP_UV_IN[0] [*8] ##1 PUMP_BUFFER_CAP_UV_IN[0] [*4] |-> ##1 on == '0)
		else $error("gates on during filtered undervoltage");
	AST_ENA_LOW_OFF: assert property (!DRIVER_ENABLE_IN [*2] |-> on == '0)
		else $error("gates on while enable low");
	AST_ENA_LOW_CODE: assert property (!DRIVER_ENABLE_IN [*2] |-> code != 2'b10)
		else $error("short or overcurrent code shown while disabled");
endmodule
bind bdfs_top bdfs_chk u_chk (
	.MCLK_IN(MCLK_IN),
	.RST_N_IN(RST_N_IN),
	.DRIVER_ENABLE_IN(DRIVER_ENABLE_IN),
	.SLEEP_INHIBIT_N_IN(SLEEP_INHIBIT_N_IN),
	.HIGH_SIDE_CMD_IN(HIGH_SIDE_CMD_IN),
	.LOW_SIDE_CMD_IN(LOW_SIDE_CMD_IN),
	.PUMP_BUFFER_CAP_UV_IN(PUMP_BUFFER_CAP_UV_IN),
	.HIGH_SIDE_GATE_OUT(HIGH_SIDE_GATE_OUT),
	.LOW_SIDE_GATE_OUT(LOW_SIDE_GATE_OUT),
	.LOGIC_READY_OUT(LOGIC_READY_OUT),
	.FAULT_CODE_HI_OUT(FAULT_CODE_HI_OUT),
	.FAULT_CODE_LO_OUT(FAULT_CODE_LO_OUT)
);
`default_nettype wire

// [sim/bdfs_host.sv]
/*
 * bdfs_host: host controller model driving gate commands, enable and the
 * overcurrent threshold strap. Assumes the core clock as its time base.
 */
`timescale 1ns/1ps
`default_nettype none
module bdfs_host import bdfs_pkg::*; (
	input wire logic clk_in, // core clock
	output logic [PHASES-1:0] hs_cmd_out, // high-side commands
	output logic [PHASES-1:0] ls_cmd_out, // low-side commands
	output logic enable_out, // enable pin
	output logic oc_gnd_out // threshold strapped to ground
);
	// outputs disabled at start so no switch turns on before the pumps settle
	initial begin
		hs_cmd_out = '0;
		ls_cmd_out = '0;
		enable_out = 1'b0;
		oc_gnd_out = 1'b0;
	end
	// the caller holds enable low for a full reset time when it wants a clear
	task automatic drive(input logic [PHASES-1:0] h, input logic [PHASES-1:0] l, input logic e);
		@(posedge clk_in);
		#1;
		hs_cmd_out = h;
		ls_cmd_out = l;
		enable_out = e;
	endtask
	task automatic oc_gnd(input logic v);
		@(posedge clk_in);
		#1;
		oc_gnd_out = v;
	endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
/*
 * testbench: directed scenarios for the supervisor with a host model.
 * Assumes bdfs_top with a short wake count and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import bdfs_pkg::*;;
	logic mclk, rst_n, sleep_inhibit_n, sc_off, ocmp, ot, hio_uv, hio_ov, ready, fc_hi, fc_lo;
	logic [2:0] hs_cmd, ls_cmd, hs_det, ls_det, hs_gate, ls_gate;
	logic enable, oc_gnd;
	logic [1:0] uv, ov, pump_en, code;
	int num_errors = 0, check_count = 0, cyc = 0;
	assign code = {fc_hi, fc_lo};

	bdfs_top #(.WAKE_CYCLES(20)) u_dut (
		.MCLK_IN(mclk), .RST_N_IN(rst_n), .DRIVER_ENABLE_IN(enable), .SLEEP_INHIBIT_N_IN(sleep_inhibit_n),
		.HIGH_SIDE_CMD_IN(hs_cmd), .LOW_SIDE_CMD_IN(ls_cmd), .HS_SHORT_DETECT_IN(hs_det),
		.LS_SHORT_DETECT_IN(ls_det), .SHORT_LIMIT_LEVEL_OFF_IN(sc_off), .OVERCURRENT_CMP_IN(ocmp),
		.OVERCURRENT_THRESHOLD_IN_GND_IN(oc_gnd), .PUMP_BUFFER_CAP_UV_IN(uv), .SUPPLY_OV_IN(ov),
		.OVERTEMP_IN(ot), .HOST_IO_SUPPLY_UV_IN(hio_uv), .HOST_IO_SUPPLY_OV_IN(hio_ov),
		.HIGH_SIDE_GATE_OUT(hs_gate), .LOW_SIDE_GATE_OUT(ls_gate), .PUMP_ENABLE_OUT(pump_en),
		.LOGIC_READY_OUT(ready), .FAULT_CODE_HI_OUT(fc_hi), .FAULT_CODE_LO_OUT(fc_lo));
	bdfs_host u_host (.clk_in(mclk), .hs_cmd_out(hs_cmd), .ls_cmd_out(ls_cmd), .enable_out(enable),
		.oc_gnd_out(oc_gnd));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		check("wake time", 4'(n <= 30), 4'h1);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// exactly the minimum low time: 20 sampled low edges
	task automatic enable_reset(input logic [2:0] l);
		u_host.drive(3'b000, l, 1'b0);
		tick(3);
		check("code while disabled", 4'(code), 4'(FC_OK));
		tick(16);
		u_host.drive(3'b000, l, 1'b1);
		tick(3);
	endtask

	task automatic t_dead();
		u_host.drive(3'b000, 3'b001, 1'b1);
		tick(3);
		check("low gate on", 4'(ls_gate), 4'h1);
		u_host.drive(3'b001, 3'b000, 1'b1);
		tick(1);
		check("dead gap", 4'({hs_gate, ls_gate[0]}), 4'h0);
		tick(1);
		check("dead min", 4'(hs_gate), 4'h0);
		tick(1);
		check("dead max", 4'(hs_gate), 4'h1);
		u_host.drive(3'b010, 3'b010, 1'b1);
		tick(3);
		check("both commands", 4'({hs_gate[1], ls_gate[1]}), 4'h0);
	endtask
	task automatic t_short();
		u_host.drive(3'b100, 3'b000, 1'b1);
		tick(3);
		ls_det = 3'b100;
		tick(150);
		check("off switch unmonitored", 4'(code), 4'(FC_OK));
		ls_det = 3'b000;
		hs_det = 3'b100;
		tick(100);
		hs_det = 3'b000;
		tick(40);
		hs_det = 3'b100;
		tick(25);
		check("integrator decayed", 4'(code), 4'(FC_OK));
		tick(15);
		check("short code", 4'(code), 4'(FC_SC_OC));
		hs_det = 3'b000;
		u_host.drive(3'b000, 3'b001, 1'b1);
		tick(3);
		check("short latched", 4'({hs_gate, ls_gate[0]}), 4'h0);
		check("no sleep", 4'(ready), 4'h1);
		ot = 1'b1;
		tick(3);
		check("short over temp", 4'(code), 4'(FC_SC_OC));
		ot = 1'b0;
		u_host.drive(3'b000, 3'b001, 1'b0);
		tick(4);
		u_host.drive(3'b000, 3'b001, 1'b1);
		tick(3);
		check("short pulse kept", 4'(code), 4'(FC_SC_OC));
		enable_reset(3'b001);
		check("reset clears", 4'({code, ls_gate[0]}), 4'h7);
	endtask
	task automatic t_oc();
		sc_off = 1'b1;
		ls_det = 3'b001;
		tick(150);
		check("short disabled", 4'({code, ls_gate[0]}), 4'h7);
		ocmp = 1'b1;
		tick(12);
		check("oc blanked", 4'(code), 4'(FC_OK));
		tick(6);
		check("oc code", 4'(code), 4'(FC_SC_OC));
		check("oc gates", 4'(ls_gate), 4'h1);
		ocmp = 1'b0;
		ls_det = 3'b000;
		sc_off = 1'b0;
		tick(3);
		check("oc clears", 4'(code), 4'(FC_OK));
		ocmp = 1'b1;
		tick(20);
		u_host.drive(3'b001, 3'b000, 1'b1);
		tick(6);
		check("oc commutated", 4'(code), 4'(FC_OK));
		ocmp = 1'b0;
		u_host.oc_gnd(1'b1);
		ocmp = 1'b1;
		tick(20);
		check("oc off", 4'(code), 4'(FC_OK));
		ocmp = 1'b0;
		u_host.oc_gnd(1'b0);
	endtask
	task automatic t_supplies();
		u_host.drive(3'b000, 3'b010, 1'b1);
		tick(3);
		uv = 2'b01;
		tick(8);
		check("uv filtering", 4'(ls_gate), 4'h2);
		tick(6);
		check("uv off", 4'({code, ls_gate[1]}), 4'h0);
		uv = 2'b00;
		tick(3);
		check("uv restart", 4'(ls_gate), 4'h2);
		ot = 1'b1;
		tick(3);
		check("over temp", 4'({code, ls_gate[1]}), 4'h3);
		ot = 1'b0;
		ov = 2'b10;
		tick(295);
		check("ov filtering", 4'(pump_en), 4'h3);
		tick(10);
		ov = 2'b00;
		tick(5);
		check("ov latched", 4'({code, pump_en}), 4'h4);
		uv = 2'b11;
		tick(12);
		check("ov pump uv", 4'(code), 4'(FC_UV));
		uv = 2'b00;
		enable_reset(3'b010);
		check("ov reset", 4'({pump_en, ls_gate[1]}), 4'h7);
		u_host.drive(3'b000, 3'b010, 1'b0);
		hio_uv = 1'b1;
		tick(25);
		hio_uv = 1'b0;
		u_host.drive(3'b000, 3'b010, 1'b1);
		tick(3);
		check("check disarmed", 4'({code, ls_gate[1]}), 4'h7);
		hio_ov = 1'b1;
		tick(3);
		hio_ov = 1'b0;
		tick(3);
		check("check latched", 4'({code, ls_gate[1]}), 4'h0);
		enable_reset(3'b010);
		check("check reset", 4'(code), 4'(FC_OK));
	endtask
	task automatic t_sleep();
		sleep_inhibit_n = 1'b0;
		tick(2);
		check("sleep", 4'({ready, ls_gate}), 4'h0);
		sleep_inhibit_n = 1'b1;
		wait_ready();
		tick(3);
		check("awake", 4'(ls_gate), 4'h2);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		{rst_n, sc_off, ocmp, ot, hio_uv, hio_ov, hs_det, ls_det, uv, ov} = '0;
		sleep_inhibit_n = 1'b1;
		tick(5);
		rst_n = 1'b1;
		wait_ready();
		tick(1);
		check("idle code", 4'(code), 4'(FC_OK));
		t_dead();
		t_short();
		t_oc();
		t_supplies();
		t_sleep();
		end_of_test();
	end
endmodule
`default_nettype wire
